// ---- design/ufs_sequencer.sv ----
// What this block does
// - Erase and program commands are ignored until a session start command has been received.
// - After the erase command one byte gives the block number and that block is erased.
// - After the write command four bytes give the total program length, which is captured.
// - Data arrives in 128-byte chunks, each chunk is programmed, until the total length is written.
// - On error-free completion the block tells the master it is no longer ready.
// - After completion and not-ready the indicator outputs show the normal-end pattern.
// - A failed erase or program, or a reception error after session start outside erase and chunk-program waits, stops and shows an identifying error pattern.
`timescale 1ns/1ps
`default_nettype none
module ufs_sequencer #(
    parameter bit LEN_MSB_FIRST = 1'b1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic rx_error,
    output logic slave_ready,
    output logic erase_req,
    output logic [7:0] erase_block,
    input wire logic erase_done,
    input wire logic erase_fail,
    output logic prog_valid,
    output logic [7:0] prog_data,
    input wire logic prog_ready,
    output logic prog_chunk_end,
    input wire logic prog_done,
    input wire logic prog_fail,
    output logic [3:0] led
);
    // ****************************************************************
    // Two-entry buffer between receiver and program port
    // ****************************************************************
    logic [7:0] buf_ff [2];
    logic [7:0] nxt_buf [2];
    logic [1:0] cnt_ff, nxt_cnt;
    logic wp_ff, nxt_wp, rp_ff, nxt_rp;
    logic buf_push, buf_pop;

    ufs_pkg::ufs_state_type st_ff, nxt_st;
    logic [31:0] len_ff, nxt_len;
    logic [31:0] sent_ff, nxt_sent;
    logic [1:0] lcnt_ff, nxt_lcnt;
    logic [7:0] blk_ff, nxt_blk;
    logic [7:0] ccnt_ff, nxt_ccnt;
    logic [3:0] led_ff, nxt_led;
    logic [7:0] out_ff, nxt_out;
    logic ov_ff, nxt_ov;
    logic in_data;
    logic in_stream;
    logic last_byte;

    assign in_data = (st_ff == ufs_pkg::ST_DATA);
    assign in_stream = in_data || (st_ff == ufs_pkg::ST_PROG);
    // Receiver stalls only on a full buffer; bytes still land while a chunk programs, so none is lost
    assign rx_ready = in_stream ? (cnt_ff != 2'd2) : 1'b1;
    assign buf_push = in_stream && rx_valid && rx_ready && !rx_error;
    // Pop only what the flash really takes; nothing leaves while a chunk is programming
    assign buf_pop = prog_valid && prog_ready;
    assign last_byte = (sent_ff + 32'd1 == len_ff) || (ccnt_ff == 8'(ufs_pkg::CHUNK_BYTES - 1));

    // Buffer next state; output register reloads when empty or taken
    always_comb begin
        nxt_buf = buf_ff;
        nxt_wp = wp_ff;
        nxt_rp = rp_ff;
        nxt_cnt = cnt_ff;
        nxt_out = out_ff;
        nxt_ov = ov_ff;
        if (buf_push) begin
            nxt_buf[wp_ff] = rx_data;
            nxt_wp = ~wp_ff;
        end
        if ((!ov_ff || buf_pop) && cnt_ff != 2'd0) begin
            nxt_out = buf_ff[rp_ff];
            nxt_ov = 1'b1;
            nxt_rp = ~rp_ff;
        end else if (buf_pop) begin
            nxt_ov = 1'b0;
        end
        nxt_cnt = 2'(cnt_ff + {1'b0, buf_push} - {1'b0, (nxt_rp != rp_ff)});
        if (st_ff != ufs_pkg::ST_DATA && st_ff != ufs_pkg::ST_PROG) begin
            nxt_cnt = 2'd0;
            nxt_ov = 1'b0;
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_len = len_ff;
        nxt_sent = sent_ff;
        nxt_lcnt = lcnt_ff;
        nxt_blk = blk_ff;
        nxt_ccnt = ccnt_ff;
        nxt_led = led_ff;
        unique case (st_ff)
            ufs_pkg::ST_IDLE: begin
                if (rx_valid && rx_data == ufs_pkg::CMD_SESSION_START && !rx_error) begin
                    nxt_st = ufs_pkg::ST_CMD;
                end
            end
            ufs_pkg::ST_CMD: begin
                if (rx_valid && rx_error) begin
                    nxt_st = ufs_pkg::ST_ERR;
                    nxt_led = ufs_pkg::ERR_RX;
                end else if (rx_valid && rx_data == ufs_pkg::CMD_ERASE) begin
                    nxt_st = ufs_pkg::ST_BLK;
                end else if (rx_valid && rx_data == ufs_pkg::CMD_WRITE) begin
                    nxt_st = ufs_pkg::ST_LEN;
                    nxt_lcnt = 2'd0;
                    nxt_len = 32'h0;
                end else if (rx_valid) begin
                    nxt_st = ufs_pkg::ST_ERR;
                    nxt_led = ufs_pkg::ERR_CMD;
                end
            end
            ufs_pkg::ST_BLK: begin
                if (rx_valid && rx_error) begin
                    nxt_st = ufs_pkg::ST_ERR;
                    nxt_led = ufs_pkg::ERR_RX;
                end else if (rx_valid) begin
                    nxt_blk = rx_data;
                    nxt_st = ufs_pkg::ST_ERASE;
                end
            end
            ufs_pkg::ST_ERASE: begin
                if (erase_fail) begin
                    nxt_st = ufs_pkg::ST_ERR;
                    nxt_led = ufs_pkg::ERR_ERASE;
                end else if (erase_done) begin
                    nxt_st = ufs_pkg::ST_CMD;
                end
            end
            ufs_pkg::ST_LEN: begin
                if (rx_valid && rx_error) begin
                    nxt_st = ufs_pkg::ST_ERR;
                    nxt_led = ufs_pkg::ERR_RX;
                end else if (rx_valid) begin
                    // Length assembly order selectable by parameter
                    if (LEN_MSB_FIRST) begin
                        nxt_len = {len_ff[23:0], rx_data};
                    end else begin
                        nxt_len = {rx_data, len_ff[31:8]};
                    end
                    nxt_lcnt = 2'(lcnt_ff + 2'd1);
                    if (lcnt_ff == 2'(ufs_pkg::LEN_BYTES - 1)) begin
                        nxt_st = ufs_pkg::ST_DATA;
                        nxt_sent = 32'h0;
                        nxt_ccnt = 8'h00;
                        if (nxt_len == 32'h0) begin
                            nxt_st = ufs_pkg::ST_DONE;
                            nxt_led = ufs_pkg::END_PATTERN;
                        end
                    end
                end
            end
            ufs_pkg::ST_DATA: begin
                if (rx_valid && rx_error) begin
                    nxt_st = ufs_pkg::ST_ERR;
                    nxt_led = ufs_pkg::ERR_RX;
                end else if (buf_pop) begin
                    nxt_sent = sent_ff + 32'd1;
                    nxt_ccnt = 8'(ccnt_ff + 8'd1);
                    if (last_byte) begin
                        nxt_st = ufs_pkg::ST_PROG;
                    end
                end
            end
            ufs_pkg::ST_PROG: begin
                if (prog_fail) begin
                    nxt_st = ufs_pkg::ST_ERR;
                    nxt_led = ufs_pkg::ERR_PROG;
                end else if (prog_done) begin
                    nxt_ccnt = 8'h00;
                    if (sent_ff == len_ff) begin
                        nxt_st = ufs_pkg::ST_DONE;
                        nxt_led = ufs_pkg::END_PATTERN;
                    end else begin
                        nxt_st = ufs_pkg::ST_DATA;
                    end
                end
            end
            ufs_pkg::ST_DONE: begin
                nxt_st = ufs_pkg::ST_DONE;
            end
            ufs_pkg::ST_ERR: begin
                nxt_st = ufs_pkg::ST_ERR;
            end
            default: begin
                nxt_st = ufs_pkg::ST_ERR;
            end
        endcase
    end

    // Registers; terminal states hold until reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= ufs_pkg::ST_IDLE;
            len_ff <= 32'h0;
            sent_ff <= 32'h0;
            lcnt_ff <= 2'd0;
            blk_ff <= 8'h00;
            ccnt_ff <= 8'h00;
            led_ff <= 4'h0;
            buf_ff[0] <= 8'h00;
            buf_ff[1] <= 8'h00;
            cnt_ff <= 2'd0;
            wp_ff <= 1'b0;
            rp_ff <= 1'b0;
            out_ff <= 8'h00;
            ov_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            len_ff <= nxt_len;
            sent_ff <= nxt_sent;
            lcnt_ff <= nxt_lcnt;
            blk_ff <= nxt_blk;
            ccnt_ff <= nxt_ccnt;
            led_ff <= nxt_led;
            buf_ff <= nxt_buf;
            cnt_ff <= nxt_cnt;
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            out_ff <= nxt_out;
            ov_ff <= nxt_ov;
        end
    end

    // Outputs
    assign slave_ready = (st_ff != ufs_pkg::ST_DONE) && (st_ff != ufs_pkg::ST_ERR);
    assign erase_req = (st_ff == ufs_pkg::ST_ERASE);
    assign erase_block = blk_ff;
    assign prog_valid = ov_ff && in_data;
    assign prog_data = out_ff;
    assign prog_chunk_end = (st_ff == ufs_pkg::ST_PROG);
    assign led = led_ff;
endmodule : ufs_sequencer
`default_nettype wire

// ---- design/ufs_pkg.sv ----
package ufs_pkg;
    // ****************************************************************
    // Command codes and widths
    // ****************************************************************
    localparam logic [7:0] CMD_SESSION_START = 8'hA5; // Arbitrary command code
    localparam logic [7:0] CMD_ERASE = 8'h45;
    localparam logic [7:0] CMD_WRITE = 8'h57;
    localparam int CHUNK_BYTES = 128;
    localparam int LEN_BYTES = 4;
    localparam logic [3:0] END_PATTERN = 4'hF;
    localparam logic [3:0] ERR_RX = 4'h1;
    localparam logic [3:0] ERR_ERASE = 4'h2;
    localparam logic [3:0] ERR_PROG = 4'h3;
    localparam logic [3:0] ERR_CMD = 4'h4;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_CMD = 4'h1,
        ST_BLK = 4'h2,
        ST_ERASE = 4'h3,
        ST_LEN = 4'h4,
        ST_DATA = 4'h5,
        ST_PROG = 4'h6,
        ST_DONE = 4'h7,
        ST_ERR = 4'h8
    } ufs_state_type;
endpackage : ufs_pkg

// ---- testbench/ufs_sequencer_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module ufs_sequencer_sva (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic slave_ready,
    input wire logic erase_req,
    input wire logic erase_done,
    input wire logic erase_fail,
    input wire logic prog_valid,
    input wire logic [7:0] prog_data,
    input wire logic prog_ready,
    input wire logic prog_chunk_end,
    input wire logic prog_done,
    input wire logic prog_fail,
    input wire logic [3:0] led
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ********
    // Flash handshakes and outcome
    // ********
    erase_hold_a: assert property (erase_req && !erase_done && !erase_fail |=> erase_req)
        else $error("erase dropped early");
    erase_drop_a: assert property (erase_req && erase_done |=> !erase_req)
        else $error("erase kept after done");
    byte_hold_a: assert property (prog_valid && !prog_ready |=> prog_valid && $stable(prog_data))
        else $error("byte changed unaccepted");
    chunk_hold_a: assert property (prog_chunk_end && !prog_done && !prog_fail |=> prog_chunk_end)
        else $error("chunk end dropped");
    end_notready_a: assert property (led == ufs_pkg::END_PATTERN |-> !slave_ready)
        else $error("end shown while ready");
    notready_keep_a: assert property (!slave_ready |=> !slave_ready && $stable(led))
        else $error("outcome changed");
    erase_err_a: assert property (erase_req && erase_fail |-> ##[1:4] led == ufs_pkg::ERR_ERASE)
        else $error("no erase error shown");
    prog_err_a: assert property (prog_chunk_end && prog_fail |-> ##[1:4] led == ufs_pkg::ERR_PROG)
        else $error("no program error shown");
endmodule : ufs_sequencer_sva
`default_nettype wire

// ---- testbench/ufs_flash_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ufs_flash_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic erase_req,
    input wire logic prog_chunk_end,
    input wire logic [1:0] fail_sel,
    input wire logic stall,
    output logic erase_done,
    output logic erase_fail,
    output logic prog_ready,
    output logic prog_done,
    output logic prog_fail
);
    logic [3:0] cnt_ff;
    int seed = 5;
    // Fixed busy time then one answer pulse; a second pulse would end the next job early
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= 4'h0;
            {erase_done, erase_fail, prog_done, prog_fail} <= 4'h0;
            prog_ready <= 1'b1;
        end else begin
            cnt_ff <= (erase_req || prog_chunk_end) ? cnt_ff + 4'h1 : 4'h0;
            erase_done <= erase_req && cnt_ff == 4'h4 && !fail_sel[0];
            erase_fail <= erase_req && cnt_ff == 4'h4 && fail_sel[0];
            prog_done <= prog_chunk_end && cnt_ff == 4'h4 && !fail_sel[1];
            prog_fail <= prog_chunk_end && cnt_ff == 4'h4 && fail_sel[1];
            prog_ready <= !stall || $random(seed) % 2 == 0;
        end
    end
endmodule : ufs_flash_model
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic rx_valid = 1'b0;
    logic rx_error = 1'b0;
    logic [1:0] fail_sel = 2'h0;
    logic stall = 1'b0;
    logic rx_ready, slave_ready, erase_req, erase_done, erase_fail, prog_valid, prog_ready;
    logic prog_chunk_end, prog_done, prog_fail, pe_ff, pc_ff;
    logic [7:0] erase_block, prog_data, eblk, blk;
    logic [3:0] led;
    int seed = 32'h0027;
    int fail_count = 0;
    int samples_checked = 0;
    int n_erase, n_chunk;
    logic [7:0] got[$];
    logic [7:0] exp_q[$];
    always #20 clk = ~clk;
    ufs_sequencer i_dut (.clk, .arst_n, .rx_data, .rx_valid, .rx_ready, .rx_error, .slave_ready, .erase_req,
        .erase_block, .erase_done, .erase_fail, .prog_valid, .prog_data, .prog_ready, .prog_chunk_end,
        .prog_done, .prog_fail, .led);
    ufs_flash_model i_flash (.clk, .arst_n, .erase_req, .prog_chunk_end, .fail_sel, .stall, .erase_done,
        .erase_fail, .prog_ready, .prog_done, .prog_fail);
    // Watch the flash side mid-cycle, where everything has settled
    always @(negedge clk) begin
        if (prog_valid && prog_ready) got.push_back(prog_data);
        if (erase_req && !pe_ff) n_erase++;
        if (erase_req && !pe_ff) eblk = erase_block;
        if (prog_chunk_end && !pc_ff) n_chunk++;
        pe_ff = erase_req;
        pc_ff = prog_chunk_end;
    end
    function automatic int n_chunks(input int len);
        return (len + ufs_pkg::CHUNK_BYTES - 1) / ufs_pkg::CHUNK_BYTES;
    endfunction : n_chunks
    function automatic logic [3:0] err_of(input int k);
        case (k)
            0: return ufs_pkg::ERR_RX;
            1: return ufs_pkg::ERR_ERASE;
            2: return ufs_pkg::ERR_PROG;
            default: return ufs_pkg::ERR_CMD;
        endcase
    endfunction : err_of
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk
    // Byte is held until a rising edge finds the receiver ready
    task automatic send(input logic [7:0] b, input logic e = 1'b0);
        logic r;
        rx_data <= b;
        rx_valid <= 1'b1;
        rx_error <= e;
        do begin
            @(negedge clk) r = rx_ready;
            @(posedge clk);
        end while (r !== 1'b1);
        rx_valid <= 1'b0;
        rx_error <= 1'b0;
        @(posedge clk);
    endtask : send
    task automatic rst(input logic [1:0] f, input logic s);
        arst_n <= 1'b0;
        fail_sel <= f;
        stall <= s;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        n_erase = 0;
        n_chunk = 0;
        got.delete();
        exp_q.delete();
        @(posedge clk);
    endtask : rst
    task automatic wr(input int len);
        logic [7:0] b;
        send(ufs_pkg::CMD_WRITE);
        for (int i = 3; i >= 0; i--) send(len[8*i +: 8]);
        for (int i = 0; i < len; i++) begin
            b = 8'($random(seed));
            exp_q.push_back(b);
            send(b);
        end
    endtask : wr
    task automatic wait_end();
        for (int i = 0; i < 3000 && slave_ready !== 1'b0; i++) @(negedge clk);
        // A sequence that never ends counts against the run
        if (slave_ready !== 1'b0) fail_count++;
        repeat (4) @(posedge clk);
    endtask : wait_end
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    // Generous bound: the whole run needs a few thousand cycles, this allows 25000
    initial begin
        #1000000;
        fail_count++;
        tally_and_finish();
    end
    initial begin
        int lens[3];
        lens = '{128, 129, 1 + {$random(seed)} % 300};
        // Commands before the session opens must do nothing
        rst(2'h0, 1'b0);
        send(ufs_pkg::CMD_ERASE);
        send(8'h11);
        wr(0);
        repeat (20) @(posedge clk);
        chk("early erase", n_erase, 0);
        chk("early end", slave_ready, 1'b1);
        blk = 8'($random(seed));
        send(ufs_pkg::CMD_SESSION_START);
        send(ufs_pkg::CMD_ERASE);
        send(blk);
        for (int i = 0; i < 200 && (n_erase == 0 || erase_req !== 1'b0); i++) @(negedge clk);
        if (n_erase == 0 || erase_req !== 1'b0) fail_count++;
        @(posedge clk);
        wr(0);
        wait_end();
        chk("erase count", n_erase, 1);
        chk("erase block", eblk, blk);
        chk("end led", led, ufs_pkg::END_PATTERN);
        chk("not ready", slave_ready, 1'b0);
        $display("test erase done");
        // Chunk boundaries with the flash stalling the stream
        foreach (lens[k]) begin
            rst(2'h0, 1'b1);
            send(ufs_pkg::CMD_SESSION_START);
            wr(lens[k]);
            wait_end();
            chk("byte count", got.size(), lens[k]);
            foreach (exp_q[i]) chk("prog byte", got[i], exp_q[i]);
            chk("chunks", n_chunk, n_chunks(lens[k]));
            chk("end led", led, ufs_pkg::END_PATTERN);
            $display("test write %0d done", lens[k]);
        end
        // Each failure kind stops the run with its own code
        for (int k = 0; k < 4; k++) begin
            rst(2'(k), 1'b0);
            send(ufs_pkg::CMD_SESSION_START);
            case (k)
                0: send(ufs_pkg::CMD_WRITE, 1'b1);
                1: begin
                    send(ufs_pkg::CMD_ERASE);
                    send(8'h22);
                end
                2: wr(3);
                default: send(8'h00);
            endcase
            wait_end();
            chk("error led", led, err_of(k));
            chk("stopped", slave_ready, 1'b0);
            $display("test error %0d done", k);
        end
        tally_and_finish();
    end
endmodule : testbench
bind ufs_sequencer ufs_sequencer_sva i_sva (.clk, .arst_n, .slave_ready, .erase_req, .erase_done, .erase_fail,
    .prog_valid, .prog_data, .prog_ready, .prog_chunk_end, .prog_done, .prog_fail, .led);
`default_nettype wire
